// *** verilog/pit_counter.sv ***
// one 16-bit down counter of the interval timer with its latches
//
// Our own choices: the register addresses and the plain strobed port.
`include "pit_consts.svh"
module pit_counter
    import pit_pkg::*;
(
    input  wire logic         CLK,
    input  wire logic         RST_N,
    input  wire logic         cnt_clk_in,    // raw counting clock pin
    input  wire logic         gate,          // gate level, already synchronous
    input  wire logic         cfg_wr,        // new control word for this counter
    input  wire counter_cfg_s cfg_in,
    input  wire logic         latch_cnt,     // count latch request
    input  wire logic         latch_st,      // status latch request
    input  wire logic         data_wr,       // host writes count byte
    input  wire logic         data_rd,       // host reads a byte
    input  wire logic [7:0]   wdata,
    output logic      [7:0]   rdata,         // byte returned if data_rd
    output logic              out_lvl,       // counter output
    output logic              tc_pulse       // one pulse at terminal count
);
    // ============================================================
    // pin synchroniser and edge detector
    logic        clk_s1_r;        // first stage, read only by clk_s2_r
    logic        clk_s2_r;
    logic        clk_s3_r;        // delayed copy for edge detection
    logic        tick;            // one counting clock edge

    always_ff @(posedge CLK)
    begin
        // two stages before anything looks at the pin
        if (!RST_N)
        begin
            clk_s1_r <= 1'b0;
            clk_s2_r <= 1'b0;
            clk_s3_r <= 1'b0;
        end
        else
        begin
            clk_s1_r <= cnt_clk_in;
            clk_s2_r <= clk_s1_r;
            clk_s3_r <= clk_s2_r;
        end
    end

    // falling edge decrements, as the classic part does
    assign tick = clk_s3_r & ~clk_s2_r;

    // ============================================================
    // state
    counter_cfg_s cfg_r;          // programmed settings
    logic [15:0]  init_r;         // count register written by host
    logic [15:0]  ce_r;           // counting element
    logic [15:0]  ol_r;           // output latch
    logic         ol_held_r;      // output latch frozen by a latch command
    logic [7:0]   st_r;           // latched status byte
    logic         st_held_r;      // status waiting to be read
    logic         null_r;         // pending-load flag
    logic         load_r;         // count waits for next tick to load
    logic         wr_msb_r;       // next write byte is the high byte
    logic         rd_msb_r;       // next read byte is the high byte
    logic         armed_r;        // counting enabled after a load
    logic         out_r;
    logic         tc_r;

    // ============================================================
    // decrement by one or two, binary or four decades
    function automatic logic [15:0] dec(input logic [15:0] v, input logic bcd);
        logic [15:0] r;
        r = v - 16'h0001;
        if (bcd)
        begin
            if (v[3:0] == 4'h0)
            begin
                r[3:0] = 4'h9;
                if (v[7:4] == 4'h0)
                begin
                    r[7:4] = 4'h9;
                    if (v[11:8] == 4'h0)
                    begin
                        r[11:8] = 4'h9;
                        r[15:12] = (v[15:12] == 4'h0) ? 4'h9 : v[15:12] - 4'h1;
                    end
                    else
                        r[15:8] = {v[15:12], v[11:8] - 4'h1};
                end
                else
                    r[15:4] = {v[15:8], v[7:4] - 4'h1};
            end
        end
        return r;
    endfunction

    logic        sq_mode;
    logic [15:0] step1;
    logic [15:0] step2;
    assign sq_mode = cfg_r.mode[1:0] == 2'b11;
    assign step1   = dec(ce_r, cfg_r.bcd);
    assign step2   = dec(step1, cfg_r.bcd);

    // ============================================================
    // configuration and host byte pointers
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            cfg_r    <= counter_cfg_s'(`CTRL_RESET);
            init_r   <= `COUNT_RESET;
            wr_msb_r <= 1'b0;
        end
        else if (cfg_wr)
        begin
            cfg_r    <= cfg_in;
            wr_msb_r <= cfg_in.fmt == `FMT_HIGH;
        end
        else if (data_wr)
        begin
            // byte order follows the access format
            unique case (cfg_r.fmt)
                `FMT_LOW:  init_r <= {8'h00, wdata};
                `FMT_HIGH: init_r <= {wdata, 8'h00};
                default:
                begin
                    if (wr_msb_r)
                        init_r[15:8] <= wdata;
                    else
                        init_r[7:0] <= wdata;
                    wr_msb_r <= ~wr_msb_r;
                end
            endcase
        end
    end

    // a write completes the count on its last byte of the format
    logic count_done;
    assign count_done = data_wr & (cfg_r.fmt != `FMT_BOTH | wr_msb_r);

    // ============================================================
    // counting element, load and output
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            ce_r    <= `COUNT_RESET;
            null_r  <= 1'b0;
            load_r  <= 1'b0;
            armed_r <= 1'b0;
            out_r   <= 1'b1;
            tc_r    <= 1'b0;
        end
        else
        begin
            tc_r <= 1'b0;
            if (cfg_wr)
            begin
                // programming stops counting until a count arrives
                armed_r <= 1'b0;
                load_r  <= 1'b0;
                out_r   <= cfg_in.mode != MODE_TC_INT;
            end
            else if (count_done)
            begin
                null_r <= 1'b1;
                load_r <= 1'b1;
            end
            else if (tick && load_r)
            begin
                // new count enters the element only on a counting edge
                ce_r    <= init_r;
                null_r  <= 1'b0;
                load_r  <= 1'b0;
                armed_r <= 1'b1;
                if (cfg_r.mode == MODE_TC_INT)
                    out_r <= 1'b0;
            end
            else if (tick && armed_r && gate)
            begin
                ce_r <= sq_mode ? step2 : step1;
                if ((sq_mode ? step2 : step1) == 16'h0000)
                begin
                    tc_r <= 1'b1;
                    unique case (cfg_r.mode[1:0])
                        2'b10, 2'b11:
                        begin
                            // periodic modes reload and keep running
                            ce_r  <= init_r;
                            out_r <= sq_mode ? ~out_r : 1'b1;
                        end
                        default:
                            out_r <= cfg_r.mode != MODE_SW_STROBE;
                    endcase
                end
                else if (cfg_r.mode[1:0] == 2'b10 && step1 == 16'h0001)
                    out_r <= 1'b0;
            end
        end
    end

    // ============================================================
    // output latch and status latch
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            ol_r      <= `COUNT_RESET;
            ol_held_r <= 1'b0;
            st_r      <= 8'h00;
            st_held_r <= 1'b0;
            rd_msb_r  <= 1'b0;
        end
        else
        begin
            if (!ol_held_r)
                ol_r <= ce_r;
            if (cfg_wr)
            begin
                ol_held_r <= 1'b0;
                st_held_r <= 1'b0;
                rd_msb_r  <= cfg_in.fmt == `FMT_HIGH;
            end
            else
            begin
                // an unread latch ignores further latch requests
                if (latch_cnt && !ol_held_r)
                begin
                    ol_r      <= ce_r;
                    ol_held_r <= 1'b1;
                end
                if (latch_st && !st_held_r)
                begin
                    st_r      <= {out_r, null_r, cfg_r};
                    st_held_r <= 1'b1;
                end
                if (data_rd)
                begin
                    if (st_held_r)
                        st_held_r <= 1'b0;
                    else if (cfg_r.fmt == `FMT_BOTH && !rd_msb_r)
                        rd_msb_r <= 1'b1;
                    else
                    begin
                        ol_held_r <= 1'b0;
                        rd_msb_r  <= cfg_r.fmt == `FMT_HIGH;
                    end
                end
            end
        end
    end

    // status first, then the count bytes in programmed order
    always_comb
    begin
        if (st_held_r)
            rdata = st_r;
        else if (rd_msb_r)
            rdata = ol_r[15:8];
        else
            rdata = ol_r[7:0];
    end

    assign out_lvl  = out_r;
    assign tc_pulse = tc_r;
endmodule

// *** verilog/pit_consts.svh ***
// constants of the three-counter interval timer: offsets, fields and codes
`ifndef PIT_CONSTS_SVH
`define PIT_CONSTS_SVH

// ============================================================
// register offsets (byte wide port, index addressing)
`define ADDR_PICK_FIRST_COUNTER       3'h0
`define ADDR_PICK_SECOND_COUNTER       3'h1
`define ADDR_PICK_THIRD_COUNTER       3'h2
`define ADDR_CTRL       3'h3
`define ADDR_IRQ_STAT   3'h4
`define ADDR_IRQ_CLR    3'h5
`define ADDR_IRQ_EN     3'h6
`define ADDR_GATE       3'h7

// ============================================================
// control word fields
`define SEL_HI          7
`define SEL_LO          6
`define FMT_HI          5
`define FMT_LO          4
`define MODE_HI         3
`define MODE_LO         1
`define BCD_BIT         0
`define SEL_READBACK    2'h3
`define FMT_LATCH       2'h0
`define FMT_LOW         2'h1
`define FMT_HIGH        2'h2
`define FMT_BOTH        2'h3
`define RB_NO_COUNT     5
`define RB_NO_STATE     4

// ============================================================
// status byte fields
`define ST_OUT          7
`define ST_NULL         6

// ============================================================
// reset values
`define CTRL_RESET      6'h00
`define COUNT_RESET     16'h0000
`define IRQ_EN_RESET    3'h0
`define GATE_RESET      3'h7

// ============================================================
// timing: highest counting clock
`define CNT_CLK_MAX_MHZ 10

`endif

// *** verilog/pit_pkg.sv ***
// types shared by the interval timer modules
package pit_pkg;

    // ============================================================
    // counting modes
    typedef enum logic [2:0]
    {
        MODE_TC_INT   = 3'b000,
        MODE_ONESHOT  = 3'b001,
        MODE_RATE     = 3'b010,
        MODE_SQUARE   = 3'b011,
        MODE_SW_STROBE= 3'b100,
        MODE_HW_STROBE= 3'b101,
        MODE_RATE_X   = 3'b110,
        MODE_SQUARE_X = 3'b111
    } count_mode_e;

    // ============================================================
    // programmed settings of one counter (status byte low six bits)
    typedef struct packed
    {
        logic [1:0]  fmt;
        count_mode_e mode;
        logic        bcd;
    } counter_cfg_s;

    // ============================================================
    // register port request
    typedef struct packed
    {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;

endpackage

// *** verilog/pit_top.sv ***
// three-counter programmable interval timer with byte register port
// ============================================================
`include "pit_consts.svh"
module pit_top
    import pit_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RST_N,
    input  wire logic [2:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    input  wire logic [2:0] CNT_CLK,
    output logic      [7:0] RDATA,
    output logic      [2:0] CNT_OUT,
    output logic            IRQ
);
    import pit_pkg::*;

    // ============================================================
    // request carrier
    reg_req_s    req;              // bundled host access
    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    // ============================================================
    // control word decode
    logic        ctrl_wr;          // write to control register
    logic [1:0]  sel;              // counter selector field
    logic [1:0]  fmt;              // access format field
    logic        is_rb;            // read-back command
    logic [2:0]  cfg_wr;           // per counter new control word
    logic [2:0]  latch_cnt;        // per counter count latch
    logic [2:0]  latch_st;         // per counter status latch
    logic [2:0]  data_wr;
    logic [2:0]  data_rd;
    counter_cfg_s cfg_word;
    logic [7:0]  cnt_rdata [3];
    logic [2:0]  out_lvl;
    logic [2:0]  tc;
    logic [2:0]  gate_r;           // software gate levels
    logic [2:0]  irq_stat_r;       // sticky terminal count events
    logic [2:0]  irq_en_r;         // interrupt enables

    assign ctrl_wr  = req.wr && req.addr == `ADDR_CTRL;
    assign sel      = req.wdata[`SEL_HI:`SEL_LO];
    assign fmt      = req.wdata[`FMT_HI:`FMT_LO];
    assign is_rb    = sel == `SEL_READBACK;
    assign cfg_word = counter_cfg_s'(req.wdata[`FMT_HI:`BCD_BIT]);

    // ============================================================
    // per-counter decode and instance
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : gen_cnt
            logic pick;    // this counter named by selector
            logic rb_pick; // this counter named by read-back mask
            assign pick    = !is_rb && sel == 2'(g);
            // read-back mask: D1 first counter, D2 second, D3 third
            assign rb_pick = is_rb && req.wdata[g + 1];
            assign cfg_wr[g]    = ctrl_wr && pick && fmt != `FMT_LATCH;
            assign latch_cnt[g] = ctrl_wr && ((pick && fmt == `FMT_LATCH)
                                  || (rb_pick && !req.wdata[`RB_NO_COUNT]));
            assign latch_st[g]  = ctrl_wr && rb_pick && !req.wdata[`RB_NO_STATE];
            assign data_wr[g]   = req.wr && req.addr == 3'(g);
            assign data_rd[g]   = req.rd && req.addr == 3'(g);

            pit_counter u_cnt
            (
                .CLK        (CLK),
                .RST_N      (RST_N),
                .cnt_clk_in (CNT_CLK[g]),
                .gate       (gate_r[g]),
                .cfg_wr     (cfg_wr[g]),
                .cfg_in     (cfg_word),
                .latch_cnt  (latch_cnt[g]),
                .latch_st   (latch_st[g]),
                .data_wr    (data_wr[g]),
                .data_rd    (data_rd[g]),
                .wdata      (req.wdata),
                .rdata      (cnt_rdata[g]),
                .out_lvl    (out_lvl[g]),
                .tc_pulse   (tc[g])
            );
        end
    endgenerate

    // ============================================================
    // interrupt status: set beats clear in the same cycle
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            irq_stat_r <= 3'h0;
        else if (req.wr && req.addr == `ADDR_IRQ_CLR)
            irq_stat_r <= (irq_stat_r & ~req.wdata[2:0]) | tc;
        else
            irq_stat_r <= irq_stat_r | tc;
    end

    // software settings: interrupt enables and gates
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            irq_en_r <= `IRQ_EN_RESET;
            gate_r   <= `GATE_RESET;
        end
        else if (req.wr && req.addr == `ADDR_IRQ_EN)
            irq_en_r <= req.wdata[2:0];
        else if (req.wr && req.addr == `ADDR_GATE)
            gate_r <= req.wdata[2:0];
    end

    // interrupt level, registered
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            IRQ <= 1'b0;
        else
            IRQ <= |(irq_stat_r & irq_en_r);
    end

    // output levels, registered
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            CNT_OUT <= 3'h0;
        else
            CNT_OUT <= out_lvl;
    end

    // ============================================================
    // read data, one cycle after the read strobe; unmapped reads zero
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            RDATA <= 8'h00;
        else if (req.rd)
        begin
            unique case (req.addr)
                `ADDR_PICK_FIRST_COUNTER:     RDATA <= cnt_rdata[0];
                `ADDR_PICK_SECOND_COUNTER:     RDATA <= cnt_rdata[1];
                `ADDR_PICK_THIRD_COUNTER:     RDATA <= cnt_rdata[2];
                `ADDR_IRQ_STAT: RDATA <= {5'h00, irq_stat_r};
                `ADDR_IRQ_EN:   RDATA <= {5'h00, irq_en_r};
                `ADDR_GATE:     RDATA <= {5'h00, gate_r};
                default:        RDATA <= 8'h00;
            endcase
        end
        else
            RDATA <= 8'h00;
    end
endmodule

// *** test/pit_top_properties.sv ***
// checker of the timer's read port, settings read-back and interrupt line
`include "pit_consts.svh"
module pit_top_checker
(
    input wire logic       CLK,
    input wire logic       RST_N,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [2:0] CNT_CLK,
    input wire logic [7:0] RDATA,
    input wire logic [2:0] CNT_OUT,
    input wire logic       IRQ
);
    default clocking dc @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic [2:0] en_r;      // shadow of the interrupt enables
    logic [5:0] cfg_r [3]; // shadow of each counter's settings
    // ============================================================
    // shadows follow host writes; latch and read-back words leave settings alone
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            en_r  <= 3'h0;
            cfg_r <= '{default: 6'h00};
        end
        else if (WR && ADDR == `ADDR_IRQ_EN)
            en_r <= WDATA[2:0];
        else if (WR && ADDR == `ADDR_CTRL && WDATA[7:6] != `SEL_READBACK
                 && WDATA[5:4] != `FMT_LATCH)
            cfg_r[WDATA[7:6]] <= WDATA[5:0];
    end
    // ============================================================
    property p_rdata_idle;
        !$past(RD) |-> RDATA == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
    property p_irq_masked;
        (en_r == 3'h0) [*3] |-> !IRQ;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("interrupt while masked");
    property p_irq_reset;
        $rose(RST_N) |-> !IRQ;
    endproperty
    a_irq_reset: assert property (p_irq_reset) else $error("interrupt out of reset");
    property p_irq_fall;
        $fell(IRQ) |-> $past(WR) || $past(WR, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped unasked");
    property p_status_cfg;
        (WR && ADDR == `ADDR_CTRL && WDATA == 8'he2) ##1 (RD && ADDR == `ADDR_PICK_FIRST_COUNTER)
        |=> RDATA[5:0] == cfg_r[0];
    endproperty
    a_status_cfg: assert property (p_status_cfg) else $error("status settings wrong");
    property p_readback_multi;
        (WR && ADDR == `ADDR_CTRL && WDATA == 8'hee) ##1 (RD && ADDR == `ADDR_PICK_THIRD_COUNTER)
        |=> RDATA[5:0] == cfg_r[2];
    endproperty
    a_readback_multi: assert property (p_readback_multi) else $error("group status wrong");
    property p_pending;
        CNT_CLK[0] [*4] ##0 (WR && ADDR == `ADDR_PICK_FIRST_COUNTER && cfg_r[0][5:4] == `FMT_LOW)
        ##1 (CNT_CLK[0] && WR && ADDR == `ADDR_CTRL && WDATA == 8'he2)
        ##1 (CNT_CLK[0] && RD && ADDR == `ADDR_PICK_FIRST_COUNTER) |=> RDATA[`ST_NULL];
    endproperty
    a_pending: assert property (p_pending) else $error("pending load flag clear");
    property p_latch_steady;
        logic [7:0] v;
        CNT_CLK[0] [*4] ##0 (WR && ADDR == `ADDR_CTRL && WDATA == 8'h00 && cfg_r[0][5:4] == 2'h1)
        ##1 (CNT_CLK[0] && RD && ADDR == `ADDR_PICK_FIRST_COUNTER) ##1 (CNT_CLK[0], v = RDATA)
        ##1 (CNT_CLK[0] && WR && ADDR == `ADDR_CTRL && WDATA == 8'h00)
        ##1 (CNT_CLK[0] && RD && ADDR == `ADDR_PICK_FIRST_COUNTER) |=> RDATA == v;
    endproperty
    a_latch_steady: assert property (p_latch_steady) else $error("latched count moved");
endmodule

bind pit_top pit_top_checker chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .CNT_CLK(CNT_CLK), .RDATA(RDATA), .CNT_OUT(CNT_OUT), .IRQ(IRQ));

// *** test/pit_host.sv ***
// host model: byte register master, strobes one cycle, answer read a cycle later
module pit_host
(
    input  wire logic       clk,
    output logic      [2:0] addr,
    output logic      [7:0] wdata,
    output logic            wr,
    output logic            rd,
    input  wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        addr = 3'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    // strobe stays up so writes may follow back to back; idle drops it
    task wr_byte(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge clk);
    endtask
    // data is taken at the edge that closes the answer cycle
    task rd_byte(input logic [2:0] a, output logic [7:0] d);
        addr <= a;
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    task idle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
endmodule

// *** test/pit_top_tb.sv ***
// testbench of the three-counter timer: settings, latches, bcd, interrupt
`include "pit_consts.svh"
module pit_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_n, wr, rd, irq;
    logic [2:0]  addr, cclk, cout;
    logic [7:0]  wdata, rdata, b0, b1, l;
    logic [5:0]  cfg, cfgs [3];
    logic [15:0] n, m, m2;
    logic [31:0] seed;
    int          fails, n_tests, cyc;
    always #25 clk = ~clk;
    pit_top dut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .CNT_CLK(cclk), .RDATA(rdata), .CNT_OUT(cout), .IRQ(irq));
    pit_host h (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    function logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // counting edges: slow enough for the pin synchroniser
    task pulse(input int i, input int k);
        h.idle(1);
        repeat (k)
        begin
            cclk[i] <= 1'b0;
            repeat (4) @(posedge clk);
            cclk[i] <= 1'b1;
            repeat (4) @(posedge clk);
        end
    endtask
    task put16(input logic [2:0] c, input logic [15:0] v);
        h.wr_byte(c, v[7:0]);
        h.wr_byte(c, v[15:8]);
    endtask
    task get16(input logic [2:0] c, output logic [15:0] v);
        h.rd_byte(c, b0);
        h.rd_byte(c, b1);
        v = {b1, b0};
    endtask
    // hang guard, far above the few hundred cycles needed
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            report_and_stop();
        end
    end
    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        cclk = 3'h7;
        seed = 32'h760f99ee;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // every counter, modes 0..5, random format and coding
        for (int c = 0; c < 3; c++)
            for (int md = 0; md < 6; md++)
            begin
                seed = xs(seed);
                cfg = {(seed[1:0] == 2'h0) ? 2'h3 : seed[1:0], md[2:0], seed[2]};
                cfgs[c] = cfg;
                h.wr_byte(`ADDR_CTRL, {c[1:0], cfg});
                h.wr_byte(`ADDR_CTRL, 8'he0 | (8'h02 << c));
                h.rd_byte(c[2:0], b0);
                chk(b0[5:0], cfg);
            end
        h.wr_byte(`ADDR_CTRL, 8'hee);
        // third counter first, so the group status property sees it
        for (int c = 2; c >= 0; c--)
        begin
            h.rd_byte(c[2:0], b0);
            chk(b0[5:0], cfgs[c]);
        end
        h.rd_byte(`ADDR_GATE, b0);
        chk(b0, {5'h00, `GATE_RESET});
        $display("done settings");
        seed = xs(seed);
        n = seed[15:0] | 16'h0100;
        h.wr_byte(`ADDR_CTRL, 8'h70);
        put16(3'h1, n);
        h.wr_byte(`ADDR_CTRL, 8'he4);
        h.rd_byte(3'h1, b0);
        chk(b0[6], 1'b1);
        pulse(1, 1);
        h.wr_byte(`ADDR_CTRL, 8'he4);
        h.rd_byte(3'h1, b0);
        chk(b0[7:6], 2'b00);
        pulse(1, 3);
        h.wr_byte(`ADDR_CTRL, 8'h40);
        pulse(1, 2);
        h.wr_byte(`ADDR_CTRL, 8'h40);
        get16(3'h1, m);
        chk(m, n - 16'h0003);
        put16(3'h1, n ^ 16'h00ff);
        h.wr_byte(`ADDR_CTRL, 8'h40);
        get16(3'h1, m);
        chk(m, n - 16'h0005);
        pulse(1, 1);
        h.wr_byte(`ADDR_CTRL, 8'h40);
        get16(3'h1, m);
        chk(m, n ^ 16'h00ff);
        h.wr_byte(`ADDR_CTRL, 8'h60);
        h.wr_byte(3'h1, n[15:8]);
        pulse(1, 1);
        h.wr_byte(`ADDR_CTRL, 8'h40);
        h.rd_byte(3'h1, b0);
        chk(b0, n[15:8]);
        l = n[7:0] | 8'h01;
        h.wr_byte(`ADDR_CTRL, 8'h50);
        h.wr_byte(3'h1, l);
        pulse(1, 2);
        h.wr_byte(`ADDR_CTRL, 8'h40);
        h.rd_byte(3'h1, b0);
        chk(b0, l - 8'h01);
        $display("done latches");
        h.wr_byte(`ADDR_CTRL, 8'hb1);
        put16(3'h2, 16'h0100);
        pulse(2, 2);
        h.wr_byte(`ADDR_CTRL, 8'h80);
        get16(3'h2, m);
        chk(m, 16'h0099);
        m2 = {n[7:0], n[15:8]} | 16'h0100;
        h.wr_byte(`ADDR_CTRL, 8'h30);
        put16(3'h0, n);
        h.wr_byte(`ADDR_CTRL, 8'hb0);
        put16(3'h2, m2);
        pulse(0, 1);
        pulse(2, 1);
        h.wr_byte(`ADDR_CTRL, 8'hda);
        pulse(0, 2);
        pulse(2, 2);
        get16(3'h0, m);
        chk(m, n);
        get16(3'h2, m);
        chk(m, m2);
        // square wave: two per edge, reload and output toggle at zero
        h.wr_byte(`ADDR_CTRL, 8'h96);
        h.wr_byte(3'h2, 8'h06);
        pulse(2, 3);
        h.wr_byte(`ADDR_CTRL, 8'h80);
        h.rd_byte(3'h2, b0);
        chk({cout[2], b0}, 9'h102);
        pulse(2, 1);
        h.wr_byte(`ADDR_CTRL, 8'h80);
        h.rd_byte(3'h2, b0);
        chk({cout[2], b0}, 9'h006);
        $display("done bcd and group latch");
        h.wr_byte(`ADDR_IRQ_EN, 8'h01);
        h.wr_byte(`ADDR_CTRL, 8'h10);
        h.wr_byte(3'h0, 8'h02);
        h.wr_byte(`ADDR_CTRL, 8'he2);
        h.rd_byte(3'h0, b0);
        chk({cout[0], b0[7:6]}, 3'b001);
        pulse(0, 3);
        h.idle(2);
        #1 chk(irq, 1'b1);
        chk(cout[0], 1'b1);
        h.rd_byte(`ADDR_IRQ_STAT, b0);
        chk(b0[0], 1'b1);
        h.wr_byte(`ADDR_IRQ_EN, 8'h00);
        h.idle(3);
        #1 chk(irq, 1'b0);
        h.wr_byte(`ADDR_IRQ_CLR, 8'h01);
        h.rd_byte(`ADDR_IRQ_STAT, b0);
        chk(b0[0], 1'b0);
        h.wr_byte(`ADDR_IRQ_EN, 8'h01);
        h.idle(3);
        #1 chk(irq, 1'b0);
        h.wr_byte(`ADDR_CTRL, 8'h00);
        h.rd_byte(3'h0, b0);
        h.wr_byte(`ADDR_CTRL, 8'h00);
        h.rd_byte(3'h0, b1);
        chk(b1, b0);
        // a counting edge after the latch must not reach the held byte
        h.wr_byte(`ADDR_CTRL, 8'h00);
        pulse(0, 1);
        h.rd_byte(3'h0, b0);
        chk(b0, 8'h00);
        h.wr_byte(`ADDR_CTRL, 8'h00);
        h.rd_byte(3'h0, b1);
        chk(b1, 8'hff);
        $display("done interrupt");
        report_and_stop();
    end
endmodule
